// ### logic/nmp_clk_if.sv
// Interface carrying the port clock enables between the clock divider and the top.
// Assumes both sides run on sys_clk.
`timescale 1ns/1ps
interface nmp_clk_if;
  logic       port_tick;
  logic [1:0] src_sel;
  modport gen (input src_sel, output port_tick);
  modport use_side (output src_sel, input port_tick);
endinterface : nmp_clk_if

// ### logic/nmp_clk_src.sv
// Port clock source: selects pin edges or a divided core clock as an enable.
// Assumes the external clock pin is already synchronous to sys_clk.
`timescale 1ns/1ps
module nmp_clk_src
  import nmp_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic port_clock_in,
  nmp_clk_if.gen    clk_if
);

  logic [2:0] div_cnt_reg;
  logic       pin_last_reg;
  logic [2:0] div_last;

  assign div_last = (clk_if.src_sel == NMP_SRC_CORE_D6) ? NMP_DIV6_LAST : NMP_DIV4_LAST;

  always_ff @(posedge sys_clk) begin
    if (rst || div_cnt_reg >= div_last) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // Loaded during reset as well, so a pin resting high shows no false edge at release.
  always_ff @(posedge sys_clk) begin
    pin_last_reg <= port_clock_in;
  end

  // Each tick is one half period of the selected port input clock.
  always_comb begin
    case (clk_if.src_sel)
      NMP_SRC_CORE_D4,
      NMP_SRC_CORE_D6: clk_if.port_tick = (div_cnt_reg == div_last);
      default:         clk_if.port_tick = port_clock_in ^ pin_last_reg;
    endcase
  end

endmodule : nmp_clk_src

// ### logic/nmp_pkg.sv
// Constants, types and the overview for the narrow memory port clock and strobe block.
// Assumes one 10 MHz system clock that also stands for the core clock.
//
// Overview of operation
// - On the first clock after reset, straps pick port clock: external pin, core divided by four or six.
// - Second output clock is port clock divided by one, two or four.
// - First output clock runs at the port clock frequency, undivided.
// - Synchronous mode: shared pin is address strobe when select is 0, read enable if 1.
// - Shared pin one: async read enable, SDRAM column strobe, sync strobe or read enable.
// - Shared pin two: async output enable, SDRAM row strobe, sync output enable.
// - The port answers a hold request by driving hold acknowledge.
// - Bus request output shows that the port itself needs the external bus while its pins float for a hold.
// - Peripheral direct transfer output lets two peripherals exchange data directly while the port owns its pins.
package nmp_pkg;

  // ---------------------------------------------------------------
  // Clock source and memory type codes
  // ---------------------------------------------------------------
  localparam logic [1:0] NMP_SRC_PIN     = 2'h0;
  localparam logic [1:0] NMP_SRC_CORE_D4 = 2'h1;
  localparam logic [1:0] NMP_SRC_CORE_D6 = 2'h2;
  localparam logic [1:0] NMP_SRC_RESET   = NMP_SRC_PIN;
  // Last divider count of each half period, so every tick marks one output clock edge.
  localparam logic [2:0] NMP_DIV4_LAST   = 3'h1;
  localparam logic [2:0] NMP_DIV6_LAST   = 3'h2;
  localparam logic [1:0] NMP_RATIO_1     = 2'h0;
  localparam logic [1:0] NMP_RATIO_2     = 2'h1;
  localparam logic [1:0] NMP_RATIO_4     = 2'h2;

  typedef enum logic [1:0] {
    NMP_MEM_ASYNC = 2'h0,
    NMP_MEM_SDRAM = 2'h1,
    NMP_MEM_SYNC  = 2'h2
  } nmp_mem_e;

  typedef enum logic [3:0] {
    NMP_ST_IDLE    = 4'h1,
    NMP_ST_ACCESS  = 4'h2,
    NMP_ST_RELEASE = 4'h4,
    NMP_ST_HELD    = 4'h8
  } nmp_state_e;

endpackage : nmp_pkg

// ### logic/nmp_top.sv
// Narrow memory port clocking, shared strobe pins and bus hold arbitration.
// Assumes synchronous inputs and an access engine that reports start and finish.
`timescale 1ns/1ps
module nmp_top
  import nmp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       port_clock_in,
  input  wire logic [1:0] port_address_straps,
  input  wire logic [1:0] clk2_ratio,
  input  wire logic [1:0] mem_type,
  input  wire logic       read_enable_select,
  input  wire logic       access_req,
  input  wire logic       access_done,
  input  wire logic       read_strobe,
  input  wire logic       output_strobe,
  input  wire logic       periph_xfer_req,
  input  wire logic       hold_request_in,
  output logic            port_clock_out_full,
  output logic            port_clock_out_divided,
  output logic            strobe_a_out,
  output logic            strobe_a_oe_n,
  output logic            strobe_b_out,
  output logic            strobe_b_oe_n,
  output logic            hold_acknowledge_out,
  output logic            bus_request_out,
  output logic            peripheral_direct_transfer,
  output logic            access_grant,
  output logic [1:0]      port_source
);

  // ---------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------
  nmp_clk_if clk_if ();
  logic [1:0] src_reg;
  logic       strap_taken_reg;

  // Straps are caught on the first clock after reset release, never under reset.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_taken_reg <= 1'b0;
      src_reg         <= NMP_SRC_RESET;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      src_reg         <= (port_address_straps == 2'h3) ? NMP_SRC_PIN : port_address_straps;
    end
  end

  // The chosen source is shown outside so a board check can confirm the straps.
  assign clk_if.src_sel = src_reg;
  assign port_source    = src_reg;

  // The divider restarts with reset, so the first core tick lands a fixed count after release.
  nmp_clk_src u_clk_src (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .port_clock_in (port_clock_in),
    .clk_if        (clk_if.gen)
  );

  // ---------------------------------------------------------------
  // Output clocks
  // ---------------------------------------------------------------
  logic [1:0] div2_cnt_reg;
  logic       full_reg;
  logic       div_reg;
  logic       div_tick;

  assign port_clock_out_full    = full_reg;
  assign port_clock_out_divided = div_reg;

  // Ticks mark both edges of the port input clock, so toggling on every tick
  // keeps the full clock at the input frequency; pin edges show one cycle late.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_reg <= 1'b0;
    end else if (clk_if.port_tick) begin
      full_reg <= ~full_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div2_cnt_reg <= 2'h0;
    end else if (clk_if.port_tick) begin
      div2_cnt_reg <= div2_cnt_reg + 2'h1;
    end
  end

  // Ratio code 3 is not defined, so it falls back to no division.
  always_comb begin
    case (clk2_ratio)
      NMP_RATIO_2: div_tick = clk_if.port_tick & div2_cnt_reg[0];
      NMP_RATIO_4: div_tick = clk_if.port_tick & (&div2_cnt_reg);
      default:     div_tick = clk_if.port_tick;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg <= 1'b0;
    end else if (div_tick) begin
      div_reg <= ~div_reg;
    end
  end

  // ---------------------------------------------------------------
  // Bus ownership
  // ---------------------------------------------------------------
  // Hold beats a new access in idle, but a running access is never cut short,
  // so the host waits for at most one access before the pins float.
  nmp_state_e state_reg;
  nmp_state_e state_next;

  always_comb begin
    case (state_reg)
      NMP_ST_IDLE: begin
        if (hold_request_in) begin
          state_next = NMP_ST_RELEASE;
        end else if (access_req) begin
          state_next = NMP_ST_ACCESS;
        end else begin
          state_next = NMP_ST_IDLE;
        end
      end
      NMP_ST_ACCESS:  state_next = access_done ? NMP_ST_IDLE : NMP_ST_ACCESS;
      NMP_ST_RELEASE: state_next = hold_request_in ? NMP_ST_HELD : NMP_ST_IDLE;
      NMP_ST_HELD:    state_next = hold_request_in ? NMP_ST_HELD : NMP_ST_IDLE;
      default:        state_next = NMP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= NMP_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The port drives its pins unless it is releasing them or the host holds the bus.
  logic owned;
  assign owned = (state_reg != NMP_ST_RELEASE) && (state_reg != NMP_ST_HELD);

  // Acknowledge rises with the entry to held, when the pins already float.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_acknowledge_out <= 1'b0;
    end else begin
      hold_acknowledge_out <= (state_next == NMP_ST_HELD);
    end
  end

  assign access_grant = (state_reg == NMP_ST_ACCESS);

  // ---------------------------------------------------------------
  // Bus request and peripheral transfer
  // ---------------------------------------------------------------
  // An access wanted while the host holds the bus waits and is flagged here.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_request_out <= 1'b0;
    end else begin
      bus_request_out <= access_req && !owned;
    end
  end

  // Direct transfers need the port's own pins, so they stop during a hold.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      peripheral_direct_transfer <= 1'b0;
    end else begin
      peripheral_direct_transfer <= periph_xfer_req && owned;
    end
  end

  // ---------------------------------------------------------------
  // Shared strobe pins
  // ---------------------------------------------------------------
  logic a_reg;
  logic b_reg;

  // Pin A is read enable in every mode except the synchronous address strobe,
  // which is only asserted while an access holds the bus.
  function automatic logic nmp_pin_a_level(
    input logic [1:0] mode,
    input logic       sel,
    input logic       grant,
    input logic       rd
  );
    logic level;
    level = ~rd;
    if (mode == NMP_MEM_SYNC && !sel) begin
      level = ~(grant & ~rd);
    end
    return level;
  endfunction : nmp_pin_a_level

  // Strobes are active low; the pins float while the host holds the bus.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      a_reg <= 1'b1;
    end else begin
      a_reg <= nmp_pin_a_level(mem_type, read_enable_select, access_grant, read_strobe);
    end
  end

  // Pin B is an output enable or row strobe whose level follows the request in every mode.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b_reg <= 1'b1;
    end else begin
      b_reg <= ~output_strobe;
    end
  end

  assign strobe_a_out  = a_reg;
  assign strobe_b_out  = b_reg;
  assign strobe_a_oe_n = ~owned;
  assign strobe_b_oe_n = ~owned;

endmodule : nmp_top

// ### tb/nmp_host_model.sv
// Host model that takes the memory bus through the hold request pair.
// Assumes go from the bench says when the host wants the bus.
`timescale 1ns/1ps
module nmp_host_model (
  input  wire logic sys_clk,
  input  wire logic go,
  input  wire logic hold_acknowledge_out,
  output logic      hold_request_in
);
  // -------------------------------------------------------------
  // Hold request
  // -------------------------------------------------------------
  logic go_seen = 1'b0;
  initial hold_request_in = 1'b0;
  // The bench flag is taken on the rising edge, so it never races the falling
  // edge on which the bench itself changes it.
  always @(posedge sys_clk) go_seen <= go;
  // The host keeps asking until it is granted, so the port never sees a
  // request that vanishes halfway through the release.
  always @(negedge sys_clk) begin
    if (go_seen)
      hold_request_in <= 1'b1;
    else if (hold_acknowledge_out)
      hold_request_in <= 1'b0;
  end
endmodule : nmp_host_model

// ### tb/nmp_top_assertions.sv
// Checker for the port clock, strobe enables and hold handshake.
// Assumes it is bound to nmp_top and sees only its ports.
`timescale 1ns/1ps
module nmp_top_assertions
  import nmp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       access_done,
  input wire logic       hold_request_in,
  input wire logic       port_clock_out_full,
  input wire logic       strobe_a_oe_n,
  input wire logic       strobe_b_oe_n,
  input wire logic       hold_acknowledge_out,
  input wire logic       access_grant,
  input wire logic [1:0] port_source
);
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_ack_after_req: assert property (
    hold_request_in && !access_grant && !hold_acknowledge_out && !strobe_a_oe_n
    |-> ##[1:2] hold_acknowledge_out) else $error("hold ack late");
  chk_ack_cause: assert property (
    $rose(hold_acknowledge_out) |-> $past(hold_request_in)) else $error("ack unasked");
  chk_ack_drop: assert property (
    !hold_request_in && hold_acknowledge_out |=> !hold_acknowledge_out)
    else $error("ack held too long");
  chk_ack_released: assert property (
    hold_acknowledge_out |-> strobe_a_oe_n && strobe_b_oe_n) else $error("bus not released");
  chk_grant_excl: assert property (
    !(access_grant && hold_acknowledge_out)) else $error("grant during hold");
  chk_grant_kept: assert property (
    access_grant && !access_done |=> access_grant) else $error("access cut short");
  chk_src_legal: assert property (
    port_source != 2'h3) else $error("bad source");
  chk_src_stable: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable(port_source)) else $error("source moved");
  chk_full_d4: assert property (
    port_source == NMP_SRC_CORE_D4 && $stable(port_source) && $changed(port_clock_out_full)
    |=> $stable(port_clock_out_full) ##1 $changed(port_clock_out_full))
    else $error("full clock d4 wrong");
  chk_full_d6: assert property (
    port_source == NMP_SRC_CORE_D6 && $stable(port_source) && $changed(port_clock_out_full)
    |=> $stable(port_clock_out_full) [*2] ##1 $changed(port_clock_out_full))
    else $error("full clock d6 wrong");
  cover property ($rose(hold_acknowledge_out));
  cover property (access_grant && hold_request_in);
  cover property (port_source == NMP_SRC_CORE_D6);
endmodule : nmp_top_assertions
bind nmp_top nmp_top_assertions u_nmp_top_assertions (.*);

// ### tb/nmp_top_tb.sv
// Self-checking bench for nmp_top with a host model on the hold pins.
// Assumes the package constants and a 10 MHz clock.
`timescale 1ns/1ps
module nmp_top_tb;
  import nmp_pkg::*;
  logic sys_clk = 0, rst = 1, port_clock_in = 0, read_enable_select = 0;
  logic access_req = 0, access_done = 0, read_strobe = 0, output_strobe = 0;
  logic periph_xfer_req = 0, go = 0, hold_request_in;
  logic [1:0] port_address_straps = 0, clk2_ratio = 0, mem_type = 0, port_source;
  logic port_clock_out_full, port_clock_out_divided, strobe_a_out, strobe_a_oe_n;
  logic strobe_b_out, strobe_b_oe_n, hold_acknowledge_out, bus_request_out;
  logic peripheral_direct_transfer, access_grant;
  logic [31:0] v;
  integer errors = 0, num_checks = 0, cyc = 0, seed = 32'h023e4565, s, r, p, i, e;
  nmp_top u_nmp_top (.*);
  nmp_host_model u_nmp_host_model (.*);
  // -------------------------------------------------------------
  // Clock, timeout and shared tasks
  // -------------------------------------------------------------
  initial forever #50 sys_clk = ~sys_clk;
  // The pin clock changes every five cycles, so the pin source gives a ten-cycle period.
  initial forever begin
    repeat (5) @(negedge sys_clk);
    port_clock_in = ~port_clock_in;
  end
  // The whole run needs about 1200 cycles; 5000 means a hang.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      stop_test;
    end
  end
  task automatic chk(string nm, integer exp, logic [7:0] got);
    num_checks++;
    if (got !== exp[7:0]) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp[7:0], got);
    end
  endtask : chk
  task automatic gap(input integer w, output integer t);
    logic o, n;
    integer k, j;
    o = w ? port_clock_out_divided : port_clock_out_full;
    k = 0;
    t = 0;
    for (j = 0; j < 300 && k < 2; j++) begin
      @(negedge sys_clk);
      n = w ? port_clock_out_divided : port_clock_out_full;
      t++;
      if (n && !o) begin
        k++;
        if (k == 1) t = 0;
      end
      o = n;
    end
  endtask : gap
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    for (s = 0; s < 4; s++) begin
      port_address_straps = s[1:0];
      rst = 1;
      repeat (10) @(negedge sys_clk);
      rst = 0;
      repeat (3) @(negedge sys_clk);
      chk("source", (s == 3) ? 0 : s, port_source);
      e = (s == 1) ? 4 : (s == 2) ? 6 : 10;
      for (r = 0; r < 4; r++) begin
        clk2_ratio = r[1:0];
        gap(0, p);
        chk("full_period", e, p);
        gap(1, p);
        gap(1, p);
        chk("div_period", e * ((r == 1) ? 2 : (r == 2) ? 4 : 1), p);
      end
    end
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      {periph_xfer_req, read_enable_select, output_strobe, read_strobe} = v[3:0];
      mem_type = i[1:0];
      repeat (3) @(negedge sys_clk);
      if (mem_type != NMP_MEM_SYNC || read_enable_select)
        chk("strobe_a", !read_strobe, strobe_a_out);
      else
        chk("strobe_as", 1, strobe_a_out);
      chk("strobe_b", !output_strobe, strobe_b_out);
      chk("oe_n", 0, {strobe_a_oe_n, strobe_b_oe_n});
      chk("pdt", periph_xfer_req, peripheral_direct_transfer);
    end
    access_req = 1;
    repeat (2) @(negedge sys_clk);
    chk("grant", 1, access_grant);
    go = 1;
    periph_xfer_req = 1;
    repeat (4) @(negedge sys_clk);
    chk("ack_busy", 0, hold_acknowledge_out);
    access_done = 1;
    @(negedge sys_clk);
    access_done = 0;
    repeat (3) @(negedge sys_clk);
    chk("ack", 1, hold_acknowledge_out);
    chk("oe_n_held", 3, {strobe_a_oe_n, strobe_b_oe_n});
    chk("bus_req", 1, bus_request_out);
    chk("pdt_held", 0, peripheral_direct_transfer);
    chk("grant_held", 0, access_grant);
    go = 0;
    access_req = 0;
    repeat (3) @(negedge sys_clk);
    chk("ack_drop", 0, hold_acknowledge_out);
    stop_test;
  end
endmodule : nmp_top_tb
